// ==== hdl/rtu_pkg.sv ====
package rtu_pkg;

	// ==========================================================
	// Register offsets
	localparam logic [5:0] ADDR_SECONDARY_FLAGS = 6'h05;
	localparam logic [5:0] ADDR_CONTROL_BITS = 6'h09;
	localparam logic [5:0] ADDR_COUNT_READBACK = 6'h0C;
	localparam logic [5:0] ADDR_DIVIDER_CONFIG = 6'h2A;
	localparam logic [5:0] ADDR_EVENT_SELECT = 6'h2B;
	localparam logic [5:0] ADDR_RELOAD_HOLDING = 6'h2C;

	// ==========================================================
	// Field positions
	localparam int BIT_RUNNING_FLAG = 7;
	localparam int BIT_START_COMMAND = 1;
	localparam int BIT_STOP_COMMAND = 2;
	localparam int BIT_AUTO_RELOAD = 5;
	localparam int PRESCALER_MSB = 4;
	localparam int BIT_START_TX_BEGIN = 0;
	localparam int BIT_START_TX_END = 1;
	localparam int BIT_STOP_RX_BEGIN = 2;
	localparam int BIT_STOP_RX_END = 3;

	// ==========================================================
	// Reset values and counts
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] COUNT_ZERO = 8'h00;
	localparam logic [7:0] COUNT_ONE = 8'h01;
	localparam logic [4:0] PRESCALER_RESET = 5'h00;
	localparam logic [3:0] SELECT_RESET = 4'h0;
	localparam logic [31:0] DIV_ZERO = 32'h0000_0000;
	localparam logic [31:0] DIV_ONE = 32'h0000_0001;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic tx_begin;
		logic tx_end;
		logic rx_begin;
		logic rx_end;
	} rtu_events_t;

	typedef struct packed {
		logic stop_on_receive_end;
		logic stop_on_receive_begin;
		logic start_on_transmit_end;
		logic start_on_transmit_begin;
	} rtu_select_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} rtu_reg_req_t;

	typedef enum logic {
		RTU_IDLE,
		RTU_RUNNING
	} rtu_state_t;

endpackage : rtu_pkg

// ==== hdl/rtu_timer.sv ====
`timescale 1ns/100ps
module rtu_timer
	import rtu_pkg::*;
#(
	parameter int COUNT_W = 8,
	parameter int PRE_W = 5,
	parameter int DIV_W = 32
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire rtu_reg_req_t reg_req_i,
	input wire rtu_events_t events_i,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic timeout_interrupt_request_o,
	output logic running_flag_o,
	output logic [COUNT_W-1:0] count_o
);

	// ==========================================================
	// Helpers
	function automatic logic [DIV_W-1:0] tick_limit(input logic [PRE_W-1:0] pre);
		logic [DIV_W-1:0] lim;
		lim = (DIV_ONE << pre) - DIV_ONE;
		return lim;
	endfunction : tick_limit

	function automatic logic is_write(input rtu_reg_req_t req, input logic [5:0] a);
		logic hit;
		hit = req.wr && (req.addr == a);
		return hit;
	endfunction : is_write

	// ==========================================================
	// Software-visible registers
	logic [7:0] reload_holding_r;
	logic auto_reload_enable_r;
	logic [PRE_W-1:0] prescaler_field_r;
	rtu_select_t event_select_r;

	// Snapshot taken at each start
	logic act_auto_r;
	logic [PRE_W-1:0] act_pre_r;
	// Auto reload uses this copy, so a reload write mid-run waits for the next start
	logic [COUNT_W-1:0] act_reload_r;
	rtu_select_t act_sel_r;

	// Counting state
	rtu_state_t state_r;
	rtu_state_t state_nxt;
	logic [COUNT_W-1:0] count_r;
	logic [COUNT_W-1:0] count_nxt;
	logic [DIV_W-1:0] div_r;
	logic [DIV_W-1:0] div_nxt;
	logic irq_r;
	logic irq_nxt;
	logic [7:0] rd_data_r;
	logic [7:0] rd_data_nxt;
	logic rd_valid_r;
	logic running_r;

	// ==========================================================
	// Register decode
	wire wr_reload = is_write(reg_req_i, ADDR_RELOAD_HOLDING);
	wire wr_divider = is_write(reg_req_i, ADDR_DIVIDER_CONFIG);
	wire wr_select = is_write(reg_req_i, ADDR_EVENT_SELECT);
	wire wr_control = is_write(reg_req_i, ADDR_CONTROL_BITS);

	// Strobes act only in the write cycle, nothing is stored
	wire software_start_command = wr_control && reg_req_i.wdata[BIT_START_COMMAND];
	wire software_stop_command = wr_control && reg_req_i.wdata[BIT_STOP_COMMAND];

	// ==========================================================
	// Event qualification
	// Start selection uses live settings: the event itself is the start
	wire start_tx_begin = events_i.tx_begin && event_select_r.start_on_transmit_begin;
	wire start_tx_end = events_i.tx_end && event_select_r.start_on_transmit_end;
	wire start_event = start_tx_begin || start_tx_end || software_start_command;

	// Stop selection uses the snapshot taken at start
	wire stop_rx_begin = events_i.rx_begin && act_sel_r.stop_on_receive_begin;
	wire stop_rx_end = events_i.rx_end && act_sel_r.stop_on_receive_end;
	wire stop_event = stop_rx_begin || stop_rx_end || software_stop_command;

	wire is_running = (state_r == RTU_RUNNING);

	// ==========================================================
	// Prescaler tick
	wire [DIV_W-1:0] div_limit = tick_limit(act_pre_r);
	wire tick = is_running && (div_r == div_limit);

	// ==========================================================
	// Counter step on a tick
	wire count_is_zero = (count_r == COUNT_ZERO);
	wire count_is_one = (count_r == COUNT_ONE);
	wire reload_now = tick && act_auto_r && count_is_one;
	wire reach_zero = tick && !act_auto_r && count_is_one;
	wire zero_stop = tick && !act_auto_r && count_is_zero;
	wire [COUNT_W-1:0] count_dec = count_r - COUNT_ONE[COUNT_W-1:0];

	// ==========================================================
	// Next-state logic
	always_comb begin
		state_nxt = state_r;
		count_nxt = count_r;
		div_nxt = div_r;
		irq_nxt = 1'b0;
		if (start_event) begin
			// Start beats any stop arriving alongside
			state_nxt = RTU_RUNNING;
			count_nxt = reload_holding_r[COUNT_W-1:0];
			div_nxt = DIV_ZERO;
		end else if (stop_event) begin
			// Halts quietly, even on the cycle it would hit zero
			state_nxt = RTU_IDLE;
			div_nxt = DIV_ZERO;
		end else if (is_running) begin
			case (state_r)
				RTU_RUNNING: begin
					if (tick) begin
						div_nxt = DIV_ZERO;
						if (reload_now) begin
							count_nxt = act_reload_r;
							irq_nxt = 1'b1;
						end else if (reach_zero) begin
							count_nxt = COUNT_ZERO[COUNT_W-1:0];
							irq_nxt = 1'b1;
							state_nxt = RTU_IDLE;
						end else if (zero_stop) begin
							// Started from a zero reload: nothing to time
							state_nxt = RTU_IDLE;
						end else if (!count_is_zero) begin
							count_nxt = count_dec;
						end
					end else begin
						div_nxt = div_r + DIV_ONE;
					end
				end
				default: begin
					state_nxt = RTU_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Read mux
	always_comb begin
		rd_data_nxt = RESET_BYTE;
		case (reg_req_i.addr)
			ADDR_SECONDARY_FLAGS: rd_data_nxt[BIT_RUNNING_FLAG] = is_running;
			ADDR_COUNT_READBACK: rd_data_nxt[COUNT_W-1:0] = count_r;
			ADDR_DIVIDER_CONFIG: begin
				rd_data_nxt[BIT_AUTO_RELOAD] = auto_reload_enable_r;
				rd_data_nxt[PRESCALER_MSB:0] = prescaler_field_r;
			end
			ADDR_EVENT_SELECT: rd_data_nxt[BIT_STOP_RX_END:0] = event_select_r;
			ADDR_RELOAD_HOLDING: rd_data_nxt = reload_holding_r;
			// Command strobes never read back
			ADDR_CONTROL_BITS: rd_data_nxt = RESET_BYTE;
			default: rd_data_nxt = RESET_BYTE;
		endcase
	end

	// ==========================================================
	// Configuration registers: storing only, never touch count
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			reload_holding_r <= RESET_BYTE;
		end else if (wr_reload) begin
			reload_holding_r <= reg_req_i.wdata;
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			auto_reload_enable_r <= 1'b0;
			prescaler_field_r <= PRESCALER_RESET;
		end else if (wr_divider) begin
			auto_reload_enable_r <= reg_req_i.wdata[BIT_AUTO_RELOAD];
			// Values above 21 are accepted but out of range for software
			prescaler_field_r <= reg_req_i.wdata[PRESCALER_MSB:0];
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			event_select_r <= SELECT_RESET;
		end else if (wr_select) begin
			event_select_r <= reg_req_i.wdata[BIT_STOP_RX_END:0];
		end
	end

	// ==========================================================
	// Snapshot of settings at each start
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			act_auto_r <= 1'b0;
			act_pre_r <= PRESCALER_RESET;
			act_sel_r <= SELECT_RESET;
			act_reload_r <= COUNT_ZERO[COUNT_W-1:0];
		end else if (start_event) begin
			act_reload_r <= reload_holding_r[COUNT_W-1:0];
			act_auto_r <= auto_reload_enable_r;
			act_pre_r <= prescaler_field_r;
			act_sel_r <= event_select_r;
		end
	end

	// ==========================================================
	// Counting state
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_r <= RTU_IDLE;
			count_r <= COUNT_ZERO[COUNT_W-1:0];
			div_r <= DIV_ZERO;
			irq_r <= 1'b0;
			running_r <= 1'b0;
		end else begin
			running_r <= (state_nxt == RTU_RUNNING);
			state_r <= state_nxt;
			count_r <= count_nxt;
			div_r <= div_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ==========================================================
	// Read port
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_data_r <= RESET_BYTE;
			rd_valid_r <= 1'b0;
		end else begin
			rd_data_r <= reg_req_i.rd ? rd_data_nxt : RESET_BYTE;
			rd_valid_r <= reg_req_i.rd;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data_o = rd_data_r;
	assign rd_valid_o = rd_valid_r;
	assign timeout_interrupt_request_o = irq_r;
	assign running_flag_o = running_r;
	assign count_o = count_r;

endmodule : rtu_timer

// ==== sim/rtu_timer_monitor.sv ====
`timescale 1ns/100ps
module rtu_timer_monitor
	import rtu_pkg::*;
#(
	parameter int COUNT_W = 8
) (
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire rtu_reg_req_t reg_req_i,
	input wire rtu_events_t events_i,
	input wire logic [7:0] rd_data_o,
	input wire logic rd_valid_o,
	input wire logic timeout_interrupt_request_o,
	input wire logic running_flag_o,
	input wire logic [COUNT_W-1:0] count_o
);
	// ==========
	// Shadow of the settings a start copies
	logic [3:0] sel_r;
	logic [7:0] rld_r;
	logic [7:0] snp_r;
	wire logic ctl = reg_req_i.wr && reg_req_i.addr == ADDR_CONTROL_BITS;
	wire logic wsel = reg_req_i.wr && reg_req_i.addr == ADDR_EVENT_SELECT;
	wire logic wrld = reg_req_i.wr && reg_req_i.addr == ADDR_RELOAD_HOLDING;
	wire logic go = ctl && reg_req_i.wdata[1] || events_i.tx_begin && sel_r[0]
		|| events_i.tx_end && sel_r[1];
	wire logic irq = timeout_interrupt_request_o;
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_r <= 4'h0;
			rld_r <= 8'h00;
			snp_r <= 8'h00;
		end else begin
			if (go) snp_r <= rld_r;
			if (wsel) sel_r <= reg_req_i.wdata[3:0];
			if (wrld) rld_r <= reg_req_i.wdata;
		end
	end
	// ==========
	// Checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);
	a_start_loads: assert property (go |=> running_flag_o && count_o == snp_r)
		else $error("start did not load the reload value");
	a_stop_cmd_quiet: assert property (ctl && reg_req_i.wdata[2] && !go
		|=> !running_flag_o && !irq) else $error("stop command misbehaved");
	a_irq_from_one: assert property (irq |-> $past(count_o) == 8'h01)
		else $error("interrupt without a one to zero step");
	a_idle_count_held: assert property (!running_flag_o && !$past(running_flag_o)
		|-> $stable(count_o)) else $error("count moved while stopped");
	a_step_down_one: assert property (running_flag_o && $past(running_flag_o)
		&& !$past(go) && !irq && $changed(count_o) |-> count_o == $past(count_o) - 8'h01)
		else $error("count did not step down by one");
	a_zero_stops: assert property (irq && count_o == 8'h00 && !go |=> !running_flag_o)
		else $error("timer kept running at zero");
	a_auto_reloads: assert property (irq && count_o != 8'h00 |-> count_o == snp_r)
		else $error("auto reload gave a wrong count");
	a_control_reads_zero: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_CONTROL_BITS
		|=> rd_valid_o && rd_data_o == 8'h00) else $error("control bits read nonzero");
	a_count_readable: assert property (reg_req_i.rd && reg_req_i.addr == ADDR_COUNT_READBACK
		|=> rd_valid_o && rd_data_o == $past(count_o)) else $error("count readback wrong");
endmodule : rtu_timer_monitor

bind rtu_timer rtu_timer_monitor #(.COUNT_W(COUNT_W)) i_rtu_timer_monitor (.clk_i(clk_i),
	.arst_n_i(arst_n_i), .reg_req_i(reg_req_i), .events_i(events_i), .rd_data_o(rd_data_o),
	.rd_valid_o(rd_valid_o), .timeout_interrupt_request_o(timeout_interrupt_request_o),
	.running_flag_o(running_flag_o), .count_o(count_o));

// ==== sim/tb.sv ====
`timescale 1ns/100ps
module tb;
	import rtu_pkg::*;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	rtu_reg_req_t reg_req_i = '0;
	logic [3:0] events_i = 4'h0;
	logic [7:0] rd_data_o;
	logic rd_valid_o;
	logic irq;
	logic running_flag_o;
	logic [7:0] count_o;
	int failures = 0;
	int checks = 0;
	int irqs = 0;
	int n;
	// Prescaler stays within 0..21; rows hold {prescaler, reload}
	logic [15:0] rows [6] = '{16'h0001, 16'h0005, 16'h0203, 16'h0302, 16'h01FF, 16'h0401};
	logic [5:0] regs [7] = '{6'h05, 6'h09, 6'h0C, 6'h2A, 6'h2B, 6'h2C, 6'h3F};
	logic [13:0] rw [3] = '{{6'h2A, 8'h25}, {6'h2B, 8'h0F}, {6'h2C, 8'hA5}};
	always #12.5 clk_i = ~clk_i;
	always @(posedge clk_i) if (irq === 1'b1) irqs++;
	rtu_timer i_rtu_timer (.clk_i(clk_i), .arst_n_i(arst_n_i), .reg_req_i(reg_req_i),
		.events_i(events_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
		.timeout_interrupt_request_o(irq), .running_flag_o(running_flag_o), .count_o(count_o));
	// ==========
	// Bus and check helpers
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			failures++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
		@(negedge clk_i);
		reg_req_i = '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge clk_i);
		reg_req_i = '0;
	endtask : acc
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		acc(1'b0, a, 8'h00);
		chk({7'h00, rd_valid_o, rd_data_o}, {8'h01, e});
	endtask : rd
	task automatic ev(input logic [3:0] e);
		@(negedge clk_i);
		events_i = e;
		@(negedge clk_i);
		events_i = 4'h0;
	endtask : ev
	task automatic tally_and_finish();
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : tally_and_finish
	// ==========
	// Stimulus
	initial begin
		#100000;
		failures++;
		tally_and_finish();
	end
	initial begin
		repeat (2) @(negedge clk_i);
		arst_n_i = 1'b1;
		foreach (regs[i]) rd(regs[i], 8'h00);
		foreach (rw[i]) begin
			acc(1'b1, rw[i][13:8], rw[i][7:0]);
			rd(rw[i][13:8], rw[i][7:0]);
		end
		acc(1'b1, ADDR_EVENT_SELECT, 8'h00);
		foreach (rows[i]) begin
			acc(1'b1, ADDR_DIVIDER_CONFIG, {3'h0, rows[i][12:8]});
			acc(1'b1, ADDR_RELOAD_HOLDING, rows[i][7:0]);
			acc(1'b1, ADDR_CONTROL_BITS, 8'h02);
			n = 0;
			while (irq !== 1'b1 && n < 600) begin
				@(negedge clk_i);
				n++;
			end
			chk(16'(n), {8'h00, rows[i][7:0]} << rows[i][12:8]);
			chk(16'(count_o), 16'h0000);
			@(negedge clk_i);
			chk(16'(running_flag_o), 16'h0000);
		end
		// Periodic: reload 3 gives a pulse every third tick
		acc(1'b1, ADDR_DIVIDER_CONFIG, 8'h20);
		acc(1'b1, ADDR_RELOAD_HOLDING, 8'h03);
		irqs = 0;
		acc(1'b1, ADDR_CONTROL_BITS, 8'h02);
		repeat (12) @(negedge clk_i);
		chk(16'(irqs), 16'h0003);
		// Reload write mid-run, then a stop command: no interrupt may follow the stop
		acc(1'b1, ADDR_RELOAD_HOLDING, 8'h09);
		acc(1'b1, ADDR_CONTROL_BITS, 8'h04);
		n = irqs;
		repeat (4) @(negedge clk_i);
		chk(16'(irqs), 16'(n));
		// Retrigger with start and stop together
		acc(1'b1, ADDR_DIVIDER_CONFIG, 8'h00);
		acc(1'b1, ADDR_RELOAD_HOLDING, 8'h08);
		acc(1'b1, ADDR_CONTROL_BITS, 8'h02);
		acc(1'b1, ADDR_RELOAD_HOLDING, 8'h14);
		chk(16'(count_o), 16'h0006);
		acc(1'b1, ADDR_CONTROL_BITS, 8'h06);
		chk({running_flag_o, 7'h00, count_o}, 16'h8014);
		acc(1'b1, ADDR_CONTROL_BITS, 8'h04);
		acc(1'b1, ADDR_RELOAD_HOLDING, 8'hC8);
		for (int k = 0; k < 2; k++) begin
			acc(1'b1, ADDR_EVENT_SELECT, k ? 8'h0A : 8'h05);
			n = irqs;
			ev(4'h4 << k);
			chk(16'(running_flag_o), 16'h0000);
			ev(4'h8 >> k);
			chk({running_flag_o, 7'h00, count_o}, 16'h80C8);
			ev(4'h1 << k);
			chk(16'(running_flag_o), 16'h0001);
			ev(4'h2 >> k);
			chk(16'(running_flag_o), 16'h0000);
			chk(16'(irqs), 16'(n));
		end
		tally_and_finish();
	end
endmodule : tb
